// ==== hdl/swr_pkg.sv ====
// Constants, register map and state types of the sleep/wake/reset block
package swr_pkg;
   // System clock rate
   localparam int unsigned CLK_HZ        = 50_000_000;
   // Reset delay figures in their own units
   localparam int unsigned DLY_LONG_MS   = 18;
   localparam int unsigned DLY_SHORT_US  = 10;
   // Reset delay in clock cycles
   localparam int unsigned DLY_LONG_CYC  = DLY_LONG_MS * (CLK_HZ / 1000);
   localparam int unsigned DLY_SHORT_CYC = DLY_SHORT_US * (CLK_HZ / 1000000);
   localparam int unsigned DLY_W         = 20;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_STATUS  = 8'h04;
   localparam logic [7:0] REG_EVT     = 8'h08;
   localparam logic [7:0] REG_EVT_CLR = 8'h0C;
   localparam logic [7:0] REG_EVT_EN  = 8'h10;

   // Control fields
   localparam int unsigned CTRL_WDT_EN  = 0;
   localparam int unsigned CTRL_WAKE_EN = 1;
   localparam int unsigned CTRL_EXT_EN  = 2;
   localparam int unsigned CTRL_XTAL    = 3;
   localparam logic [3:0]  CTRL_RST     = 4'h5;

   // Status fields
   localparam int unsigned ST_PIN_WAKE = 0;
   localparam int unsigned ST_PWRDN_N  = 3;
   localparam int unsigned ST_TO_N     = 4;
   localparam int unsigned ST_ASLEEP   = 8;

   // Event bits
   localparam int unsigned EVT_SLEEP = 0;
   localparam int unsigned EVT_WDT   = 1;
   localparam int unsigned EVT_EXT   = 2;
   localparam int unsigned EVT_PIN   = 3;

   // Pins 0, 1, 3 and 4 take part in wake-on-change
   localparam logic [4:0] WAKE_PIN_MASK = 5'h1B;

   typedef enum logic [1:0] {
      SWR_RUN,
      SWR_SLEEP,
      SWR_DELAY
   } swr_state_e;
endpackage : swr_pkg

// ==== hdl/swr_sleep_wake.sv ====
// Sleep entry, wake-up, reset delay and reset-cause flags with Wishbone regs
// Contract
// - Watchdog wake from sleep leaves all three cause flags at 0.
// - Watchdog time-out while awake clears pin and timeout flags only.
// - External reset wake gives pin flag 0, timeout 1, powerdown 0.
// - Power-up sets powerdown and timeout flags, clears pin flag.
// - External reset while awake clears pin flag only.
// - Pin-change wake gives pin flag 1, timeout 1, powerdown 0.
// - Flags hold until a reset or sleep entry; reset pin pulse alone alters only the pin flag.
// - Power-down is entered only on the sleep opcode.
// - Sleep entry clears watchdog, sets timeout, clears powerdown, stops osc.
// - I/O pins hold their pre-sleep state during sleep.
// - Watchdog reset never drives the external reset pin low.
// - Wake on enabled reset pin, enabled watchdog, or enabled wake pin change.
// - Every wake-up is a full device reset.
// - Pin change compares against values at the last port operation.
// - Pins already differing at sleep entry wake at once.
// - Watchdog count cleared on every wake-up.
// - Watchdog wake starts the reset delay; core held in reset meanwhile.
// - Delay 18 ms after power-up; later 10 us, or 18 ms in crystal mode.
module swr_sleep_wake
   import swr_pkg::*;
#(
   // Reset delay lengths in clock cycles
   parameter int unsigned DLY_LONG  = swr_pkg::DLY_LONG_CYC,
   parameter int unsigned DLY_SHORT = swr_pkg::DLY_SHORT_CYC
) (
   // Clock and power-up reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // Register bus
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Core, port and watchdog side
   input  wire logic        sleep_opcode,
   input  wire logic        port_op,
   input  wire logic [4:0]  wake_pins,
   input  wire logic        ext_reset_pin_n,
   input  wire logic        wdt_timeout,
   // Reset, clock and pin control
   output logic             core_rst,
   output logic             wdt_clr,
   output logic             wdt_run,
   output logic             osc_en,
   output logic             io_hold,
   output logic             asleep,
   // Reset-cause flags and interrupt
   output logic             pin_wake_flag,
   output logic             timeout_flag_n,
   output logic             powerdown_flag_n,
   output logic             irq
);
   import swr_pkg::*;

   // Whole block state, registered as one word
   typedef struct packed {
      swr_state_e        st;
      logic [DLY_W-1:0]  cnt;
      logic              dly_long;
      logic              pwf;
      logic              to_n;
      logic              pwrdn_n;
      logic [3:0]        ctrl;
      logic [3:0]        evt;
      logic [3:0]        evt_en;
      logic [4:0]        last_pins;
      logic              ack;
      logic [31:0]       dat;
      logic              core_rst;
      logic              wdt_clr;
      logic              wdt_run;
      logic              osc_en;
      logic              io_hold;
      logic              asleep;
      logic              irq;
   } swr_state_s;

   // Present and next copy of the whole block state
   swr_state_s s_q;
   swr_state_s s_d;

   // Delay end points; the counter stops at the last one
   localparam logic [DLY_W-1:0] LONG_LAST  = DLY_W'(DLY_LONG - 1);
   localparam logic [DLY_W-1:0] SHORT_LAST = DLY_W'(DLY_SHORT - 1);

   // Qualified wake and reset sources
   logic             ext_low;
   logic             wdt_hit;
   logic             pin_diff;
   logic             wake_any;
   logic [4:0]       pin_delta;

   // Register bus helpers
   logic             bus_req;
   logic             bus_wr;
   logic             bus_rd;

   // Event strobes for the sticky event register
   logic [3:0]       evt_set;
   logic [3:0]       evt_clr;

   // Reset delay end point for the current reset
   logic [DLY_W-1:0] dly_last;
   logic             dly_done;

   // Reset pin only counts when it is configured as a reset
   assign ext_low   = s_q.ctrl[CTRL_EXT_EN] & ~ext_reset_pin_n;

   // Watchdog only resets when it is enabled
   assign wdt_hit   = s_q.ctrl[CTRL_WDT_EN] & wdt_timeout;

   // Pin 2 is masked out; it has no wake-on-change
   assign pin_delta = (wake_pins ^ s_q.last_pins) & WAKE_PIN_MASK;
   assign pin_diff  = s_q.ctrl[CTRL_WAKE_EN] & (|pin_delta);

   // Any enabled event ends sleep
   assign wake_any  = ext_low | wdt_hit | pin_diff;

   // One access per ack; the ack cycle ignores a strobe still held
   assign bus_req   = wb_cyc_i & wb_stb_i & ~s_q.ack;
   assign bus_wr    = bus_req & wb_we_i & wb_sel_i[0];
   assign bus_rd    = bus_req & ~wb_we_i;

   // Crystal modes need the long delay so the oscillator settles
   assign dly_last  = s_q.dly_long ? LONG_LAST : SHORT_LAST;
   assign dly_done  = (s_q.cnt >= dly_last);

   // Next-state logic for the whole block
   always_comb begin
      s_d         = s_q;
      s_d.wdt_clr = 1'b0;
      s_d.ack     = 1'b0;
      evt_set     = 4'h0;
      evt_clr     = 4'h0;

      case (s_q.st)
         SWR_RUN: begin
            // Reset sources take priority over a sleep request
            if (ext_low) begin
               // Pin reset while awake; other flags keep their value
               s_d.pwf      = 1'b0;
               s_d.st       = SWR_DELAY;
               s_d.cnt      = '0;
               s_d.dly_long = s_q.ctrl[CTRL_XTAL];
               s_d.core_rst = 1'b1;
               evt_set[EVT_EXT] = 1'b1;
            end else if (wdt_hit) begin
               // Internal reset only; the pin has no driver here
               s_d.pwf      = 1'b0;
               s_d.to_n     = 1'b0;
               s_d.st       = SWR_DELAY;
               s_d.cnt      = '0;
               s_d.dly_long = s_q.ctrl[CTRL_XTAL];
               s_d.core_rst = 1'b1;
               // Restart the watchdog so it cannot fire again at once
               s_d.wdt_clr  = 1'b1;
               evt_set[EVT_WDT] = 1'b1;
            end else if (sleep_opcode) begin
               // Only the opcode brings the block into power-down
               s_d.st       = SWR_SLEEP;
               s_d.to_n     = 1'b1;
               s_d.pwrdn_n  = 1'b0;
               s_d.wdt_clr  = 1'b1;
               s_d.osc_en   = 1'b0;
               s_d.io_hold  = 1'b1;
               s_d.asleep   = 1'b1;
               evt_set[EVT_SLEEP] = 1'b1;
            end else if (port_op) begin
               // Snapshot at each port file or bit operation
               s_d.last_pins = wake_pins;
            end
         end

         SWR_SLEEP: begin
            // A stale mismatch wakes on the first sleeping cycle
            if (wake_any) begin
               // Wake is a full reset, never a resume
               s_d.st       = SWR_DELAY;
               s_d.cnt      = '0;
               s_d.dly_long = s_q.ctrl[CTRL_XTAL];
               s_d.core_rst = 1'b1;
               s_d.wdt_clr  = 1'b1;

               // Oscillator and pins return to normal use
               s_d.osc_en   = 1'b1;
               s_d.io_hold  = 1'b0;
               s_d.asleep   = 1'b0;

               // Cause flags; the reset pin outranks the other sources
               if (ext_low) begin
                  s_d.pwf     = 1'b0;
                  s_d.to_n    = 1'b1;
                  s_d.pwrdn_n = 1'b0;
                  evt_set[EVT_EXT] = 1'b1;
               end else if (wdt_hit) begin
                  s_d.pwf     = 1'b0;
                  s_d.to_n    = 1'b0;
                  s_d.pwrdn_n = 1'b0;
                  evt_set[EVT_WDT] = 1'b1;
               end else begin
                  s_d.pwf     = 1'b1;
                  s_d.to_n    = 1'b1;
                  s_d.pwrdn_n = 1'b0;
                  evt_set[EVT_PIN] = 1'b1;
               end
            end
         end

         SWR_DELAY: begin
            // Timer restarts while the reset pin stays low; flags untouched
            if (ext_low) begin
               s_d.cnt = '0;
            end else if (dly_done) begin
               // Delay over; the core may start fetching again
               s_d.st       = SWR_RUN;
               s_d.core_rst = 1'b0;
            end else begin
               s_d.cnt = s_q.cnt + DLY_W'(1);
            end
         end

         default: begin
            // Unknown state: take the safe path through a reset delay
            s_d.st = SWR_DELAY;
         end
      endcase

      // Register writes; all fields live in byte lane 0
      if (bus_req) begin
         s_d.ack = 1'b1;
      end
      if (bus_wr) begin
         case (wb_adr_i)
            REG_CTRL:    s_d.ctrl   = wb_dat_i[3:0];
            REG_EVT_CLR: evt_clr    = wb_dat_i[3:0];
            REG_EVT_EN:  s_d.evt_en = wb_dat_i[3:0];
            default:     s_d.ctrl   = s_d.ctrl;
         endcase
      end

      // Sticky events: a set in the clearing cycle survives
      s_d.evt = (s_q.evt & ~evt_clr) | evt_set;

      // Level interrupt, registered in the same cycle as the event or the write
      s_d.irq = |(s_d.evt & s_d.evt_en);

      // Watchdog run follows its enable, also through sleep
      s_d.wdt_run = s_d.ctrl[CTRL_WDT_EN];

      // Read data; unmapped and write-only offsets read as zero
      s_d.dat = 32'h0000_0000;
      if (bus_rd) begin
         case (wb_adr_i)
            REG_CTRL: begin
               s_d.dat[3:0] = s_q.ctrl;
            end
            REG_STATUS: begin
               s_d.dat[ST_PIN_WAKE] = s_q.pwf;
               s_d.dat[ST_PWRDN_N]  = s_q.pwrdn_n;
               s_d.dat[ST_TO_N]     = s_q.to_n;
               s_d.dat[ST_ASLEEP]   = s_q.asleep;
            end
            REG_EVT: begin
               s_d.dat[3:0] = s_q.evt;
            end
            REG_EVT_EN: begin
               s_d.dat[3:0] = s_q.evt_en;
            end
            default: begin
               s_d.dat = 32'h0000_0000;
            end
         endcase
      end
   end

   // State register; power-up values of the cause flags
   // Power-up always takes the long delay, whatever the oscillator
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_q          <= '0;
         s_q.st       <= SWR_DELAY;
         s_q.dly_long <= 1'b1;
         s_q.pwf      <= 1'b0;
         s_q.to_n     <= 1'b1;
         s_q.pwrdn_n  <= 1'b1;
         s_q.ctrl     <= CTRL_RST;
         s_q.core_rst <= 1'b1;
         s_q.wdt_run  <= 1'b1;
         s_q.osc_en   <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Bus outputs straight from the state register
   assign wb_dat_o         = s_q.dat;
   assign wb_ack_o         = s_q.ack;

   // Core, watchdog and pin control outputs
   assign core_rst         = s_q.core_rst;
   assign wdt_clr          = s_q.wdt_clr;
   assign wdt_run          = s_q.wdt_run;
   assign osc_en           = s_q.osc_en;
   assign io_hold          = s_q.io_hold;
   assign asleep           = s_q.asleep;

   // Cause flags and interrupt
   assign pin_wake_flag    = s_q.pwf;
   assign timeout_flag_n   = s_q.to_n;
   assign powerdown_flag_n = s_q.pwrdn_n;
   assign irq              = s_q.irq;
endmodule : swr_sleep_wake

// ==== tb/swr_chk.sv ====
// Assertion checker for the sleep/wake/reset block
module swr_chk #(
   parameter int unsigned DLY_SHORT = 5
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic sleep_opcode,
   input wire logic ext_reset_pin_n,
   input wire logic wdt_timeout,
   input wire logic core_rst,
   input wire logic wdt_clr,
   input wire logic osc_en,
   input wire logic io_hold,
   input wire logic asleep,
   input wire logic pin_wake_flag,
   input wire logic timeout_flag_n,
   input wire logic powerdown_flag_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] held_q;
   logic [15:0] held_d;

   // Counts reset cycles so a short delay target is caught
   always_comb held_d = core_rst ? held_q + 16'h0001 : 16'h0000;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         held_q <= 16'h0000;
      end else begin
         held_q <= held_d;
      end
   end

   default clocking dcb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // Core-side and bus relations
   a_sleep_entry: assert property (
      sleep_opcode && !asleep && !core_rst && ext_reset_pin_n && !wdt_timeout
      |=> asleep && !powerdown_flag_n && timeout_flag_n)
      else $error("sleep entry wrong");
   a_only_opcode: assert property ($rose(asleep) |-> $past(sleep_opcode))
      else $error("sleep without opcode");
   a_sleep_pins: assert property (asleep |-> !osc_en && io_hold)
      else $error("oscillator or pins not held in sleep");
   a_wake_reset: assert property (
      $fell(asleep) |-> core_rst && wdt_clr)
      else $error("wake without reset and watchdog clear");
   a_wdt_wake: assert property (
      $fell(asleep) && !timeout_flag_n |-> !pin_wake_flag && !powerdown_flag_n)
      else $error("watchdog wake flags wrong");
   a_pin_wake: assert property (
      $fell(asleep) && pin_wake_flag |-> timeout_flag_n && !powerdown_flag_n)
      else $error("pin wake flags wrong");
   a_ext_wake: assert property (
      $fell(asleep) && !$past(ext_reset_pin_n)
      |-> !pin_wake_flag && timeout_flag_n && !powerdown_flag_n)
      else $error("reset pin wake flags wrong");
   a_flag_hold: assert property ($rose(pin_wake_flag) |-> core_rst)
      else $error("pin flag set outside reset");
   a_delay_min: assert property (
      $fell(core_rst) |-> held_q >= 16'(DLY_SHORT - 1))
      else $error("reset delay too short");
   a_bus_ack: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not one cycle");

   // Main scenarios reached
   c_pin_wake: cover property ($fell(asleep) && pin_wake_flag);
   c_wdt_wake: cover property ($fell(asleep) && !timeout_flag_n);
   c_release: cover property ($fell(core_rst));
endmodule : swr_chk

bind swr_sleep_wake swr_chk #(.DLY_SHORT(DLY_SHORT)) i_chk (.clk_sys, .rst,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o, .sleep_opcode, .ext_reset_pin_n,
   .wdt_timeout, .core_rst, .wdt_clr, .osc_en, .io_hold, .asleep,
   .pin_wake_flag, .timeout_flag_n, .powerdown_flag_n);

// ==== tb/swr_pins.sv ====
// Model of the reset pin and the wake-on-change pins
module swr_pins (
   input  wire logic       pull_low,
   input  wire logic [4:0] pin_lvl,
   output logic            ext_reset_pin_n,
   output logic      [4:0] wake_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // Reset pin rests at its pull-up unless pulled low
   assign ext_reset_pin_n = !pull_low;
   assign wake_pins       = pin_lvl;
endmodule : swr_pins

// ==== tb/tb_top.sv ====
// Self-checking testbench for the sleep/wake/reset block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import swr_pkg::*;
   logic        clk_sys, rst, cyc, stb, we, slp, pop, pull_low, wdt_to;
   logic        ack, ext_n, crst, osc, hold, slpd, pwf, ton, pdn, irq;
   logic        wrun;
   logic [7:0]  adr;
   logic [31:0] wdat, dout, rdat;
   logic [4:0]  pin_lvl, pins;
   int          fails, checked;

   swr_sleep_wake #(.DLY_LONG(40), .DLY_SHORT(5)) i_dut (.clk_sys, .rst,
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
      .sleep_opcode(slp), .port_op(pop), .wake_pins(pins),
      .ext_reset_pin_n(ext_n), .wdt_timeout(wdt_to), .core_rst(crst),
      .wdt_clr(), .wdt_run(wrun), .osc_en(osc), .io_hold(hold), .asleep(slpd),
      .pin_wake_flag(pwf), .timeout_flag_n(ton), .powerdown_flag_n(pdn),
      .irq(irq));
   swr_pins i_pins (.pull_low, .pin_lvl, .ext_reset_pin_n(ext_n),
      .wake_pins(pins));

   // 50 MHz clock
   always #10 clk_sys = ~clk_sys;

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check

   // Classic cycle; data taken at the edge that sees ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do begin
         @(posedge clk_sys);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rdat = dout;
      cyc  <= 1'b0;
      stb  <= 1'b0;
      if (n >= 20) begin
         fails++;
         $display("wrong value bus ack: expected 1, seen none");
      end
   endtask : wb

   task automatic flags(input logic [2:0] e);
      check("cause flags", 32'(e), {29'h0, pwf, ton, pdn});
   endtask : flags

   // Waits out the reset delay, bounded
   task automatic wait_woke;
      int n;
      repeat (3) @(posedge clk_sys);
      for (n = 0; n < 200 && crst !== 1'b0; n++) @(posedge clk_sys);
      check("core reset", 32'h0, {31'h0, crst});
      check("asleep", 32'h0, {31'h0, slpd});
   endtask : wait_woke

   // Snapshot the port, then sleep with pins set to p
   task automatic go_sleep(input logic [4:0] p);
      @(posedge clk_sys);
      pop <= 1'b1;
      @(posedge clk_sys);
      pop     <= 1'b0;
      slp     <= 1'b1;
      pin_lvl <= p;
      @(posedge clk_sys);
      slp <= 1'b0;
      @(posedge clk_sys);
   endtask : go_sleep

   task automatic kick(input logic e, input logic w);
      @(posedge clk_sys);
      pull_low <= e;
      wdt_to   <= w;
      @(posedge clk_sys);
      pull_low <= 1'b0;
      wdt_to   <= 1'b0;
   endtask : kick

   task automatic t_power;
      wait_woke();
      flags(3'b011);
      wb(1'b0, REG_CTRL, 32'h0);
      check("ctrl reset", 32'h5, rdat);
      wb(1'b0, 8'h20, 32'h0);
      check("unmapped", 32'h0, rdat);
      wb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
      wb(1'b0, REG_STATUS, 32'h0);
      check("status", 32'h18, rdat);
      check("watchdog run", 32'h1, {31'h0, wrun});
      wb(1'b1, REG_CTRL, 32'h6);
      check("watchdog off", 32'h0, {31'h0, wrun});
      kick(1'b0, 1'b1);
      repeat (2) @(posedge clk_sys);
      check("disabled wdt", 32'h0, {31'h0, crst});
      wb(1'b1, REG_CTRL, 32'h7);
      wb(1'b1, REG_EVT_EN, 32'h1);
      kick(1'b0, 1'b1);
      wait_woke();
      flags(3'b001);
   endtask : t_power

   task automatic t_pin;
      wb(1'b1, REG_EVT_CLR, 32'hF);
      go_sleep(5'h00);
      check("sleep outs", 32'hA, {28'h0, slpd, osc, hold, pdn});
      pin_lvl <= 5'h02;
      wait_woke();
      flags(3'b110);
      check("irq set", 32'h1, {31'h0, irq});
      wb(1'b0, REG_EVT, 32'h0);
      check("events", 32'h9, rdat);
      wb(1'b1, REG_EVT_CLR, 32'hF);
      wb(1'b0, REG_EVT, 32'h0);
      check("irq clear", 32'h0, {31'h0, irq});
      kick(1'b1, 1'b0);
      wait_woke();
      flags(3'b010);
   endtask : t_pin

   task automatic t_wdt;
      go_sleep(5'h02);
      pin_lvl <= 5'h06;
      repeat (6) @(posedge clk_sys);
      check("no wake pin2", 32'h1, {31'h0, slpd});
      wb(1'b0, REG_STATUS, 32'h0);
      check("status asleep", 32'h110, rdat);
      kick(1'b0, 1'b1);
      wait_woke();
      flags(3'b000);
      kick(1'b1, 1'b0);
      wait_woke();
      flags(3'b000);
   endtask : t_wdt

   task automatic t_other;
      go_sleep(5'h07);
      wait_woke();
      flags(3'b110);
      go_sleep(5'h07);
      kick(1'b1, 1'b0);
      wait_woke();
      flags(3'b010);
   endtask : t_other

   task automatic tally_and_finish;
      $display("checked %0d, fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish

   // Stimulus and watchdog
   initial begin
      {clk_sys, cyc, stb, we, slp, pop, pull_low, wdt_to} = '0;
      {adr, wdat, pin_lvl, fails, checked} = '0;
      rst = 1'b1;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      t_power();
      t_pin();
      t_wdt();
      t_other();
      tally_and_finish();
   end
   initial begin
      #100us;
      fails++;
      tally_and_finish();
   end
endmodule : tb_top
